// File: rtl/ads_pkg.sv
// Shared constants and types for the converter serial port block
package ads_pkg;
    // ==========================================================
    // Word geometry
    localparam int WORD_W      = 24;         // Conversion result width
    localparam int CMD_W       = 8;          // Received command byte width
    localparam int FIFO_DEPTH  = 4;          // Results buffered ahead of the port
    localparam int BIT_CNT_W   = 5;

    // ==========================================================
    // Timing
    localparam int CLK_MHZ         = 25;     // System clock rate
    localparam int RDY_CLR_MAX_NS  = 300;    // Longest reset-to-ready-high, internal clock
    localparam int RDY_CLR_MAX_CYC = (RDY_CLR_MAX_NS * CLK_MHZ) / 1000;  // Rounded down
    localparam int RDY_CLR_EXT_PER = 2;      // Converter clock periods, external clock

    // Rise count at which ready goes high (bit next to the last)
    localparam logic [BIT_CNT_W-1:0] RDY_CLR_RISE = 5'(WORD_W - 1);
    localparam logic [BIT_CNT_W-1:0] CMD_LAST     = 5'(CMD_W - 1);
    localparam logic [BIT_CNT_W-1:0] CNT_ZERO     = 5'h00;
    localparam logic [BIT_CNT_W-1:0] CNT_ONE      = 5'h01;

    // ==========================================================
    // Types
    typedef logic [WORD_W-1:0] ads_word_t;

    typedef struct packed {
        logic chipSelectN;
        logic sclk;
        logic sdi;
        logic resetInputN;
    } ads_pins_s;

    typedef enum logic [0:0] {
        ST_IDLE,
        ST_FRAME
    } ads_state_e;
endpackage

// File: rtl/ads_spi_ready.sv
// Serial result port with data-ready flag and result buffer
`timescale 1ns/100ps

// How it works
// - fresh result drives ready low
// - ready high at next-to-last bit's rise
// - ready line always driven
// - internal clock: reset clears ready quickly
// - external clock: reset clears ready quickly
// - serial input sampled on clock rise
// - serial output changes after clock fall
// - output released when select rises
// - output driven once select falls

// ==========================================================
// Result FIFO
module ads_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             flush,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
    logic [AW:0]      count_q, count_d;
    logic             push, pop;

    assign inReady  = (count_q != (AW+1)'(DEPTH));
    assign outValid = (count_q != '0);
    assign outData  = mem_q[rdPtr_q];
    assign push     = inValid && inReady && !flush;
    assign pop      = outValid && outReady && !flush;

    // Pointer and fill level update
    always_comb begin
        wrPtr_d = wrPtr_q;
        rdPtr_d = rdPtr_q;
        count_d = count_q;
        if (flush) begin
            wrPtr_d = '0;
            rdPtr_d = '0;
            count_d = '0;
        end else begin
            if (push) begin
                wrPtr_d = (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
            end
            if (pop) begin
                rdPtr_d = (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
            end
            count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            wrPtr_q <= wrPtr_d;
            rdPtr_q <= rdPtr_d;
            count_q <= count_d;
        end
    end

    // Storage, written only on push
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wrPtr_q] <= inData;
        end
    end
endmodule

// ==========================================================
// Serial port top
module ads_spi_ready
    import ads_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              chipSelectN,
    input  wire logic              sclk,
    input  wire logic              sdi,
    input  wire logic              resetInputN,
    input  wire logic              extClockMode,
    input  wire logic              convValid,
    output logic                   convReady,
    input  wire ads_word_t         convData,
    output logic                   dataReadyN,
    output logic                   sdoOut,
    output logic                   sdoOe,
    output logic                   cmdValid,
    output logic       [CMD_W-1:0] cmdByte
);
    // ==========================================================
    // Pin synchronisers
    ads_pins_s  pinsMeta_q, pinsSync_q, pinsPrev_q;
    ads_pins_s  pinsNow;
    logic       sclkRise, sclkFall, csFall, inReset;

    assign pinsNow  = '{chipSelectN: chipSelectN, sclk: sclk, sdi: sdi, resetInputN: resetInputN};
    assign sclkRise = pinsSync_q.sclk && !pinsPrev_q.sclk;
    assign sclkFall = !pinsSync_q.sclk && pinsPrev_q.sclk;
    assign csFall   = !pinsSync_q.chipSelectN && pinsPrev_q.chipSelectN;
    assign inReset  = !pinsSync_q.resetInputN;

    // Two stages, then an edge-detect history stage
    always_ff @(posedge clk) begin
        if (reset) begin
            pinsMeta_q <= '{chipSelectN: 1'b1, sclk: 1'b0, sdi: 1'b0, resetInputN: 1'b1};
            pinsSync_q <= '{chipSelectN: 1'b1, sclk: 1'b0, sdi: 1'b0, resetInputN: 1'b1};
            pinsPrev_q <= '{chipSelectN: 1'b1, sclk: 1'b0, sdi: 1'b0, resetInputN: 1'b1};
        end else begin
            pinsMeta_q <= pinsNow;
            pinsSync_q <= pinsMeta_q;
            pinsPrev_q <= pinsSync_q;
        end
    end

    // ==========================================================
    // Result buffer
    logic      fifoValid, fifoPop;
    ads_word_t fifoData;

    ads_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) ads_fifo_inst (
        .clk      (clk),
        .reset    (reset),
        .flush    (inReset),
        .inValid  (convValid),
        .inReady  (convReady),
        .inData   (convData),
        .outValid (fifoValid),
        .outReady (fifoPop),
        .outData  (fifoData)
    );

    // ==========================================================
    // Frame state, data register and shifters
    ads_state_e           state_q, state_d;
    ads_word_t            dataReg_q, dataReg_d, txShift_q, txShift_d;
    logic                 fresh_q, fresh_d;
    logic [BIT_CNT_W-1:0] riseCnt_q, riseCnt_d;
    logic [CMD_W-1:0]     rxShift_q, rxShift_d, cmdByte_q, cmdByte_d;
    logic                 cmdValid_q, cmdValid_d;

    // Load a new result only between frames, so a read never tears
    assign fifoPop = fifoValid && !fresh_q && (state_q == ST_IDLE) && pinsSync_q.chipSelectN && !inReset;

    always_comb begin
        state_d    = state_q;
        dataReg_d  = dataReg_q;
        txShift_d  = txShift_q;
        fresh_d    = fresh_q;
        riseCnt_d  = riseCnt_q;
        rxShift_d  = rxShift_q;
        cmdByte_d  = cmdByte_q;
        cmdValid_d = 1'b0;
        if (fifoPop) begin
            dataReg_d = fifoData;
            fresh_d   = 1'b1;
        end
        case (state_q)
            ST_IDLE: begin
                if (csFall && !inReset) begin
                    state_d   = ST_FRAME;
                    txShift_d = dataReg_q;
                    riseCnt_d = CNT_ZERO;
                end
            end
            ST_FRAME: begin
                if (pinsSync_q.chipSelectN) begin
                    state_d = ST_IDLE;
                end else begin
                    if (sclkFall) begin
                        txShift_d = {txShift_q[WORD_W-2:0], 1'b0};
                    end
                    if (sclkRise) begin
                        rxShift_d = {rxShift_q[CMD_W-2:0], pinsSync_q.sdi};
                        riseCnt_d = riseCnt_q + CNT_ONE;
                        if ((riseCnt_q & CMD_LAST) == CMD_LAST) begin  // Every eighth rise ends a byte
                            cmdByte_d  = {rxShift_q[CMD_W-2:0], pinsSync_q.sdi};
                            cmdValid_d = 1'b1;
                        end
                        if (riseCnt_q + CNT_ONE == RDY_CLR_RISE) begin
                            fresh_d = 1'b0;
                        end
                    end
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        if (inReset) begin
            fresh_d = 1'b0;
            state_d = ST_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q    <= ST_IDLE;
            dataReg_q  <= '0;
            txShift_q  <= '0;
            fresh_q    <= 1'b0;
            riseCnt_q  <= CNT_ZERO;
            rxShift_q  <= '0;
            cmdByte_q  <= '0;
            cmdValid_q <= 1'b0;
        end else begin
            state_q    <= state_d;
            dataReg_q  <= dataReg_d;
            txShift_q  <= txShift_d;
            fresh_q    <= fresh_d;
            riseCnt_q  <= riseCnt_d;
            rxShift_q  <= rxShift_d;
            cmdByte_q  <= cmdByte_d;
            cmdValid_q <= cmdValid_d;
        end
    end

    // ==========================================================
    // Outputs
    assign dataReadyN = !fresh_q;
    assign sdoOut     = (state_q == ST_FRAME) ? txShift_q[WORD_W-1] : 1'b0;
    assign sdoOe      = (state_q == ST_FRAME);
    assign cmdValid   = cmdValid_q;
    assign cmdByte    = cmdByte_q;
endmodule

// File: verification/ads_host_model.sv
// Host side serial master model
`timescale 1ns/100ps
module ads_host_model
    import ads_pkg::*;
(
    input  wire logic clk,
    input  wire logic sdoOut,
    input  wire logic sdoOe,
    output logic      chipSelectN,
    output logic      sclk,
    output logic      sdi
);
    // ==========================================================
    // Idle pins: select high, clock parked low
    initial begin
        chipSelectN = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end
    // Data line means nothing between frames, so keep it moving
    always @(posedge clk) begin
        if (chipSelectN) begin
            sdi <= ~sdi;
        end
    end
    // One frame: 24 bits out and in, MSB first, 320 ns clock
    task automatic xfer(input ads_word_t tx, output ads_word_t rx);
        rx = '0;
        @(posedge clk);
        chipSelectN <= 1'b0;
        @(posedge clk);
        for (int i = WORD_W - 1; i >= 0; i--) begin
            sdi <= tx[i];
            repeat (4) @(posedge clk);
            sclk <= 1'b1;
            rx[i] = sdoOe ? sdoOut : 1'bx;
            repeat (4) @(posedge clk);
            sclk <= 1'b0;
        end
        repeat (4) @(posedge clk);
        chipSelectN <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
endmodule

// File: verification/ads_spi_ready_monitor.sv
// Checker of the serial port pin behaviour
`timescale 1ns/100ps
module ads_spi_ready_monitor
    import ads_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic chipSelectN,
    input wire logic sclk,
    input wire logic resetInputN,
    input wire logic extClockMode,
    input wire logic dataReadyN,
    input wire logic sdoOut,
    input wire logic sdoOe,
    input wire logic cmdValid
);
    // ==========================================================
    // Pin relations, 7 cycles stay inside 300 ns
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    AST_RST_INT: assert property ($fell(resetInputN) && !extClockMode |-> ##[1:7] dataReadyN)
        else $error("ready not cleared by reset pin");
    AST_RST_EXT: assert property ($fell(resetInputN) && extClockMode |-> ##[1:7] dataReadyN)
        else $error("ready not cleared by reset pin, external clock");
    AST_SET_IDLE: assert property ($fell(dataReadyN) |-> !sdoOe)
        else $error("ready fell outside idle port");
    AST_CLR_CAUSE: assert property ($rose(dataReadyN) |-> !chipSelectN || !resetInputN)
        else $error("ready rose without read or reset");
    AST_OE_OFF: assert property ($rose(chipSelectN) |-> ##[1:5] !sdoOe)
        else $error("output not released");
    AST_OE_ON: assert property ($fell(chipSelectN) |-> ##[1:5] sdoOe)
        else $error("output not driven in frame");
    AST_QUIET: assert property (chipSelectN [*5] |-> !sdoOe && !cmdValid)
        else $error("activity outside frame");
    AST_SHIFT_LOW: assert property (sdoOe && $past(sdoOe) && $changed(sdoOut) |-> !sclk)
        else $error("output changed while clock high");
    AST_CMD_FRAME: assert property (cmdValid |-> !chipSelectN)
        else $error("byte taken outside frame");
endmodule

// File: verification/test_ads_spi_ready.sv
// Self-checking bench for the serial result port
`timescale 1ns/100ps
module test_ads_spi_ready
    import ads_pkg::*;
;
    logic             clk = 1'b0;
    logic             reset = 1'b1;
    logic             resetInputN = 1'b1;
    logic             extClockMode = 1'b0;
    logic             convValid = 1'b0;
    ads_word_t        convData = '0;
    logic             chipSelectN, sclk, sdi, convReady, dataReadyN, sdoOut, sdoOe, cmdValid;
    logic [CMD_W-1:0] cmdByte;
    ads_word_t        rx;
    int               errors = 0;
    int               totalChecks = 0;

    // ==========================================================
    // Clock, design and host
    always #20 clk = ~clk;
    ads_spi_ready ads_spi_ready_inst (.clk, .reset, .chipSelectN, .sclk, .sdi, .resetInputN, .extClockMode,
        .convValid, .convReady, .convData, .dataReadyN, .sdoOut, .sdoOe, .cmdValid, .cmdByte);
    ads_host_model ads_host_model_inst (.clk, .sdoOut, .sdoOe, .chipSelectN, .sclk, .sdi);

    // Compare and count
    task automatic chk(input string what, input ads_word_t exp, input ads_word_t got);
        totalChecks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Bounded wait for a waiting result
    task automatic wait_ready();
        int n = 0;
        while (dataReadyN !== 1'b0 && n < 400) begin
            @(posedge clk);
            n++;
        end
    endtask
    // Fill the buffer while the host stalls, then read all words in order
    task automatic fill_and_drain();
        int n = 0;
        @(posedge clk);
        convValid <= 1'b1;
        convData <= 24'ha50000;
        repeat (8) begin
            @(posedge clk);
            if (convReady === 1'b1) begin
                n++;
                convData <= 24'ha50000 + 24'(n);
            end
        end
        convValid <= 1'b0;
        chk("words taken", 24'(FIFO_DEPTH + 1), 24'(n));
        for (int k = 0; k <= FIFO_DEPTH; k++) begin
            wait_ready();
            chk("ready low", 24'h0, 24'(dataReadyN));
            ads_host_model_inst.xfer(24'h00c300 + 24'(k), rx);
            chk("word read", 24'ha50000 + 24'(k), rx);
            chk("command byte", 24'(k), 24'(cmdByte));
        end
        repeat (6) @(posedge clk);
        chk("ready after drain", 24'h1, 24'(dataReadyN));
    endtask
    // Pull the reset pin while a word waits, in both clock modes
    task automatic reset_pin_clears();
        for (int m = 0; m < 2; m++) begin
            @(posedge clk);
            extClockMode <= m[0];
            convValid <= 1'b1;
            convData <= 24'h5a5a5a;
            @(posedge clk);
            convValid <= 1'b0;
            wait_ready();
            resetInputN <= 1'b0;
            repeat (7) @(posedge clk);
            chk("ready after reset pin", 24'h1, 24'(dataReadyN));
            resetInputN <= 1'b1;
            repeat (6) @(posedge clk);
            ads_host_model_inst.xfer(24'h0, rx);
            chk("ready after stale read", 24'h1, 24'(dataReadyN));
        end
    endtask
    // Verdict and end of run
    task automatic give_verdict();
        $display("checks %0d errors %0d", totalChecks, errors);
        if (errors == 0 && totalChecks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        fill_and_drain();
        reset_pin_clears();
        give_verdict();
    end
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        give_verdict();
    end
endmodule

bind ads_spi_ready ads_spi_ready_monitor ads_spi_ready_monitor_inst (.clk, .reset, .chipSelectN, .sclk,
    .resetInputN, .extClockMode, .dataReadyN, .sdoOut, .sdoOe, .cmdValid);
